// ===== logic/sas_sequencer.sv
// conversion sequencer and parallel read port of a four-channel sampler
//
// Overview of operation
// - start pulse holds all channels, begins sequence
// - end-of-conversion pulse once per converted channel
// - busy high during sequence, low after last
// - unselected channels skipped, only selected converted
// - channel set from pins or programmed word
// - results returned as 12-bit words on reads
// - each channel conversion takes 1.65 us
// - single channel repeats up to 500 kSPS
// - four channels reach 130 kSPS reading during
// - timing comes from the on-chip clock
`timescale 1ns/1ps
module sas_sequencer (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic conversion_start_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic sel_sw,
  input wire logic [sas_pkg::NUM_CH-1:0] sel_hw,
  input wire logic [sas_pkg::NUM_CH-1:0] sel_word,
  input wire logic [sas_pkg::DATA_W-1:0] sar_data,
  output logic th_hold,
  output logic [sas_pkg::CH_W-1:0] conv_chan,
  output logic eoc_n,
  output logic busy,
  output logic [sas_pkg::DATA_W-1:0] db_o,
  output logic db_oe,
  output logic fifo_full
);

  // pin synchroniser chain
  sas_pkg::sas_pins_t pins_raw; // pins gathered
  sas_pkg::sas_pins_t pins_s1_q; // first stage, read only by second
  sas_pkg::sas_pins_t pins_s2_q; // second stage
  sas_pkg::sas_pins_t pins_s3_q; // third stage
  sas_pkg::sas_pins_t pins_q; // filtered levels

  // sequencer state
  sas_pkg::sas_state_t state_q; // idle or converting
  logic [sas_pkg::NUM_CH-1:0] pend_q; // channels still to convert
  logic [sas_pkg::NUM_CH-1:0] pend_d; // pending after current one
  logic [sas_pkg::CH_W-1:0] chan_q; // channel now converting
  logic [sas_pkg::CNT_W-1:0] cnt_q; // cycles into this conversion
  logic start_n_prev_q; // filtered start level last cycle
  logic start_evt; // falling edge of filtered start
  logic [sas_pkg::NUM_CH-1:0] sel_mask; // channel set chosen now
  logic conv_end; // conversion time elapsed
  logic push; // result accepted into buffer

  // read side
  logic rd_act; // select and read both low
  logic rd_act_prev_q; // rd_act last cycle
  logic rd_start; // read strobe just began
  logic [sas_pkg::DATA_W-1:0] db_q; // word on the bus

  // buffer signals
  logic fifo_in_ready; // buffer has room
  logic fifo_out_valid; // buffer holds a word
  logic [sas_pkg::DATA_W-1:0] fifo_out_data; // oldest word
  logic fifo_pop; // oldest word taken

  // lowest set bit of a channel mask
  function automatic logic [sas_pkg::CH_W-1:0] lowest_chan(
    input logic [sas_pkg::NUM_CH-1:0] mask
  );
    logic [sas_pkg::CH_W-1:0] idx;
    idx = sas_pkg::CH_FIRST;
    for (int i = sas_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (mask[i]) begin
        idx = sas_pkg::CH_W'(i);
      end
    end
    return idx;
  endfunction : lowest_chan

  assign pins_raw = '{start_n: conversion_start_n, cs_n: cs_n, rd_n: rd_n,
                      sel_sw: sel_sw, sel_hw: sel_hw, sel_word: sel_word};

  // three-stage pin synchroniser
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pins_s1_q <= sas_pkg::PINS_IDLE;
      pins_s2_q <= sas_pkg::PINS_IDLE;
      pins_s3_q <= sas_pkg::PINS_IDLE;
    end else begin
      pins_s1_q <= pins_raw;
      pins_s2_q <= pins_s1_q;
      pins_s3_q <= pins_s2_q;
    end
  end

  // a bit changes only once second and third stage agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pins_q <= sas_pkg::PINS_IDLE;
    end else begin
      pins_q <= (pins_s2_q & pins_s3_q) | (pins_q & (pins_s2_q | pins_s3_q));
    end
  end

  // start edge detector on the filtered level
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      start_n_prev_q <= 1'b1;
    end else begin
      start_n_prev_q <= pins_q.start_n;
    end
  end

  assign start_evt = start_n_prev_q && !pins_q.start_n;

  // channel set from the selected source
  assign sel_mask = pins_q.sel_sw ? pins_q.sel_word : pins_q.sel_hw;

  // conversion timed by the on-chip clock only
  assign conv_end = (state_q == sas_pkg::ST_CONV) && (cnt_q == sas_pkg::CNT_LAST);

  // a full buffer stalls the end of conversion
  assign push = conv_end && fifo_in_ready;

  // drop the finished channel from the pending set
  assign pend_d = pend_q & ~(sas_pkg::NUM_CH'(1) << chan_q);

  // sequencer state; starts during a sequence are ignored
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= sas_pkg::ST_IDLE;
      pend_q <= sas_pkg::MASK_NONE;
      chan_q <= sas_pkg::CH_FIRST;
    end else begin
      unique case (state_q)
        // idle: wait for a start with a non-empty set
        sas_pkg::ST_IDLE: begin
          if (start_evt && (sel_mask != sas_pkg::MASK_NONE)) begin
            state_q <= sas_pkg::ST_CONV;
            pend_q <= sel_mask;
            chan_q <= lowest_chan(sel_mask);
          end
        end
        // converting: move to next selected channel or finish
        sas_pkg::ST_CONV: begin
          if (push) begin
            pend_q <= pend_d;
            if (pend_d == sas_pkg::MASK_NONE) begin
              state_q <= sas_pkg::ST_IDLE;
            end else begin
              chan_q <= lowest_chan(pend_d);
            end
          end
        end
      endcase
    end
  end

  // conversion cycle counter, holds at the end while stalled
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= sas_pkg::CNT_ZERO;
    end else if (state_q == sas_pkg::ST_IDLE) begin
      cnt_q <= sas_pkg::CNT_ZERO;
    end else if (push) begin
      cnt_q <= sas_pkg::CNT_ZERO;
    end else if (!conv_end) begin
      cnt_q <= cnt_q + sas_pkg::CNT_ONE;
    end
  end

  // track/hold control and busy flag
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      th_hold <= 1'b0;
      busy <= 1'b0;
    end else if (state_q == sas_pkg::ST_IDLE) begin
      th_hold <= start_evt && (sel_mask != sas_pkg::MASK_NONE);
      busy <= start_evt && (sel_mask != sas_pkg::MASK_NONE);
    end else if (push && (pend_d == sas_pkg::MASK_NONE)) begin
      th_hold <= 1'b0; // back to track for the next sample
      busy <= 1'b0;
    end
  end

  // one-cycle end-of-conversion pulse per channel
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      eoc_n <= 1'b1;
    end else begin
      eoc_n <= !push;
    end
  end

  assign conv_chan = chan_q;

  // read strobe detection on filtered pins
  assign rd_act = !pins_q.cs_n && !pins_q.rd_n;
  assign rd_start = rd_act && !rd_act_prev_q;
  assign fifo_pop = rd_start;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_act_prev_q <= 1'b0;
    end else begin
      rd_act_prev_q <= rd_act;
    end
  end

  // oldest word loaded onto the bus at the start of a read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      db_q <= sas_pkg::WORD_ZERO;
    end else if (rd_start && fifo_out_valid) begin
      db_q <= fifo_out_data;
    end
  end

  // bus drive only during an active read
  assign db_o = db_q;
  assign db_oe = rd_act;
  assign fifo_full = !fifo_in_ready;

  // results in conversion order
  sas_fifo #(
    .WIDTH(sas_pkg::DATA_W),
    .DEPTH(sas_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_data(sar_data),
    .in_valid(conv_end),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop)
  );

  // helper: cycles spent in the current conversion
  logic [sas_pkg::CNT_W:0] age_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      age_q <= '0;
    end else if ((state_q == sas_pkg::ST_IDLE) || push) begin
      age_q <= '0;
    end else begin
      age_q <= age_q + 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking

  default disable iff (!nrst);

  // a start taken while idle
  sequence s_start_taken;
    (state_q == sas_pkg::ST_IDLE) && start_evt && (sel_mask != sas_pkg::MASK_NONE);
  endsequence

  // the last result of a sequence accepted
  sequence s_last_push;
    push && (pend_d == sas_pkg::MASK_NONE);
  endsequence

  a_start_hold: assert property (s_start_taken |=> th_hold && busy)
    else $error("start did not hold samples and raise busy");

  a_idle_track: assert property (s_last_push |=> !th_hold ##1 !th_hold)
    else $error("track/hold stayed in hold after sequence");

  a_eoc_single: assert property ($fell(eoc_n) |=> eoc_n)
    else $error("end-of-conversion pulse longer than one cycle");

  a_eoc_follows: assert property (!eoc_n |-> $past(push))
    else $error("end-of-conversion without a conversion");

  a_busy_end: assert property (s_last_push |=> !busy && !eoc_n)
    else $error("busy did not drop with the last conversion");

  a_skip_unsel: assert property (state_q == sas_pkg::ST_CONV |-> pend_q[chan_q])
    else $error("converting a channel not selected");

  a_src_select: assert property (s_start_taken |=> pend_q == $past(pins_q.sel_sw
                                 ? pins_q.sel_word : pins_q.sel_hw))
    else $error("channel set not taken from chosen source");

  a_conv_time: assert property (push |-> age_q >= (sas_pkg::CNT_W+1)'(sas_pkg::CONV_CYCLES - 1))
    else $error("conversion ended early");

  a_read_order: assert property (rd_start && fifo_out_valid |=> db_q == $past(fifo_out_data))
    else $error("read returned a word out of order");

  a_bus_release: assert property ($past(pins_s2_q.cs_n && pins_s3_q.cs_n) |-> !db_oe)
    else $error("bus driven outside a read");

endmodule : sas_sequencer

// ===== logic/sas_pkg.sv
// shared constants and types of the simultaneous-sampling converter sequencer
package sas_pkg;

  // clock and conversion timing
  localparam int unsigned CLK_PERIOD_NS = 50; // ref_clk period at 20 mhz
  localparam int unsigned CONV_TIME_NS = 1650; // one channel conversion
  // least time, so rounded up to whole cycles
  localparam int unsigned CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // widths and sizes
  localparam int unsigned DATA_W = 12; // result word width
  localparam int unsigned NUM_CH = 4; // analog channels
  localparam int unsigned CH_W = 2; // channel index width
  localparam int unsigned CNT_W = 6; // conversion cycle counter width
  localparam int unsigned FIFO_DEPTH = 16; // result buffer words

  // reset values, counter step and end count
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CH_W-1:0] CH_FIRST = 2'h0;
  localparam logic [NUM_CH-1:0] MASK_NONE = 4'h0;
  localparam logic [DATA_W-1:0] WORD_ZERO = 12'h000;

  // one result word
  typedef logic [DATA_W-1:0] sas_word_t;

  // pins sampled from outside the clock domain, all idle high but selects
  typedef struct packed {
    logic start_n; // conversion_start_n pin
    logic cs_n; // chip select
    logic rd_n; // read strobe
    logic sel_sw; // 1: software select word, 0: select pins
    logic [NUM_CH-1:0] sel_hw; // channel select pins
    logic [NUM_CH-1:0] sel_word; // programmed channel select word
  } sas_pins_t;

  // pin idle levels used at reset
  localparam sas_pins_t PINS_IDLE = '{start_n: 1'b1, cs_n: 1'b1, rd_n: 1'b1,
                                      sel_sw: 1'b0, sel_hw: 4'h0, sel_word: 4'h0};

  // sequencer states
  typedef enum logic {
    ST_IDLE,
    ST_CONV
  } sas_state_t;

endpackage : sas_pkg

// ===== logic/sas_fifo.sv
// result buffer fifo with registered head word
`timescale 1ns/1ps
module sas_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH]; // storage
  logic [AW-1:0] wr_ptr_q; // next write slot
  logic [AW-1:0] rd_ptr_q; // head slot
  logic [AW-1:0] rd_ptr_d; // head slot after this cycle
  logic [AW:0] count_q; // words held
  logic push; // word accepted
  logic pop; // word drained

  // honest flags from the word count
  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;

  // storage write, no reset needed
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // head word from a register, bypassing a write into the head slot
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_data <= '0;
    end else if (push && (wr_ptr_q == rd_ptr_d)) begin
      out_data <= in_data;
    end else begin
      out_data <= mem_q[rd_ptr_d];
    end
  end

endmodule : sas_fifo

// ===== tb/sas_host_model.sv
// host processor model reading results over the parallel bus
`timescale 1ns/1ps
module sas_host_model (
  input wire logic ref_clk,
  output logic cs_n,
  output logic rd_n,
  input wire logic [sas_pkg::DATA_W-1:0] db_o,
  input wire logic db_oe
);
  // bus level as the host sees it, floating unless the device drives
  wire [sas_pkg::DATA_W-1:0] db;
  assign db = db_oe ? db_o : 'z;

  // idle strobes from time zero
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
  end

  // one read strobe, held long enough for the pin filter and data edge
  task rd(output logic [sas_pkg::DATA_W-1:0] w, output logic oe);
    @(posedge ref_clk);
    #5;
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    w = db;
    oe = db_oe;
    #4;
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    // hand back just past the edge so callers never race the flops
    #1;
  endtask : rd
endmodule : sas_host_model

// ===== tb/tb.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module tb;
  logic ref_clk;
  logic nrst;
  logic conversion_start_n;
  logic sel_sw;
  logic [3:0] sel_hw;
  logic [3:0] sel_word;
  logic [9:0] seq_n; // sequence tag placed in each result
  logic [1:0] conv_chan;
  logic [11:0] sar_data;
  logic cs_n, rd_n, th_hold, eoc_n, busy, db_oe, fifo_full;
  logic [11:0] db_o;
  int mismatches;
  int comparisons;

  // converter core result: sequence tag and channel
  assign sar_data = {seq_n, conv_chan};

  sas_sequencer i_sas_sequencer (.ref_clk(ref_clk), .nrst(nrst),
    .conversion_start_n(conversion_start_n), .cs_n(cs_n), .rd_n(rd_n),
    .sel_sw(sel_sw), .sel_hw(sel_hw), .sel_word(sel_word), .sar_data(sar_data),
    .th_hold(th_hold), .conv_chan(conv_chan), .eoc_n(eoc_n), .busy(busy),
    .db_o(db_o), .db_oe(db_oe), .fifo_full(fifo_full));

  sas_host_model i_sas_host_model (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n),
    .db_o(db_o), .db_oe(db_oe));

  // 20 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // verdict and end of run
  task end_sim;
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // compare one value
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // step just past a rising edge
  task tick;
    @(posedge ref_clk);
    #1;
  endtask : tick

  // set the channel source, then a start pulse long enough for the filter
  task pulse(input logic sw, input logic [3:0] hw, input logic [3:0] word);
    repeat (8) tick();
    #4;
    sel_sw = sw;
    sel_hw = hw;
    sel_word = word;
    tick();
    #4;
    conversion_start_n = 1'b0;
    repeat (3) tick();
    #4;
    conversion_start_n = 1'b1;
  endtask : pulse

  // follow one sequence; poke retries a start while busy
  task run_seq(input int n, input bit poke);
    int t;
    int ne;
    int last;
    t = 0;
    while (busy !== 1'b1 && t < 20) begin
      tick();
      t++;
    end
    chk("busy_rise", 1, busy);
    chk("th_hold_set", 1, th_hold);
    t = 0;
    ne = 0;
    last = 0;
    while (busy === 1'b1 && t < 300) begin
      tick();
      t++;
      if (eoc_n === 1'b0) begin
        ne++;
        chk("eoc_gap", sas_pkg::CONV_CYCLES, t - last);
        last = t;
        if (poke) begin
          #4;
          conversion_start_n = (ne != 1);
        end
      end
    end
    chk("eoc_count", n, ne);
    chk("busy_end", 0, busy);
    chk("th_hold_end", 0, th_hold);
  endtask : run_seq

  // one read and its bus checks
  task read_chk(input logic [11:0] exp);
    logic [11:0] w;
    logic oe;
    i_sas_host_model.rd(w, oe);
    chk("db_oe_read", 1, oe);
    chk("read_word", exp, w);
    chk("db_oe_idle", 0, db_oe);
  endtask : read_chk

  // start a sequence and read back every selected channel
  task conv_seq(input logic sw, input logic [3:0] hw, input logic [3:0] word,
                input logic [3:0] mask, input bit poke, input logic [9:0] s);
    seq_n = s;
    pulse(sw, hw, word);
    run_seq($countones(mask), poke);
    for (int ch = 0; ch < 4; ch++) begin
      if (mask[ch]) begin
        read_chk({s, 2'(ch)});
      end
    end
  endtask : conv_seq

  // all channels from the programmed word, with a refused restart
  task t_all_sw;
    conv_seq(1'b1, 4'h0, 4'hf, 4'hf, 1'b1, 10'h001);
  endtask : t_all_sw

  // reading an empty buffer keeps the last word
  task t_empty_read;
    read_chk({10'h001, 2'h3});
  endtask : t_empty_read

  // subsets from pins and from the word, other source as decoy
  task t_subsets;
    conv_seq(1'b0, 4'ha, 4'h5, 4'ha, 1'b0, 10'h002);
    conv_seq(1'b1, 4'h9, 4'h6, 4'h6, 1'b0, 10'h003);
    conv_seq(1'b0, 4'h8, 4'h0, 4'h8, 1'b0, 10'h004);
  endtask : t_subsets

  // all four channels, each word but the last read while the rest still convert
  task t_read_during;
    seq_n = 10'h005;
    pulse(1'b0, 4'hf, 4'h0);
    for (int ch = 0; ch < 4; ch++) begin
      for (int t = 0; t < 100 && eoc_n !== 1'b0; t++) begin
        tick();
      end
      chk("eoc_mid", 0, eoc_n);
      chk("busy_mid", ch != 3, busy);
      read_chk({10'h005, 2'(ch)});
    end
    chk("busy_after", 0, busy);
  endtask : t_read_during

  // empty chosen set: start ignored
  task t_empty_set;
    pulse(1'b1, 4'hf, 4'h0);
    repeat (20) tick();
    chk("empty_word", 0, busy);
    pulse(1'b0, 4'h0, 4'hf);
    repeat (20) tick();
    chk("empty_pins", 0, busy);
  endtask : t_empty_set

  // fill the buffer, stall a conversion, drain in order
  task t_fifo_full;
    for (int s = 10; s < 14; s++) begin
      seq_n = 10'(s);
      pulse(1'b0, 4'hf, 4'h0);
      run_seq(4, 1'b0);
    end
    chk("fifo_full", 1, fifo_full);
    seq_n = 10'h00e;
    pulse(1'b0, 4'h4, 4'h0);
    repeat (60) tick();
    chk("stall_busy", 1, busy);
    for (int s = 10; s < 14; s++) begin
      for (int ch = 0; ch < 4; ch++) begin
        read_chk({10'(s), 2'(ch)});
      end
    end
    read_chk({10'h00e, 2'h2});
    chk("drain_busy", 0, busy);
    chk("drain_full", 0, fifo_full);
  endtask : t_fifo_full

  // watchdog against a hang
  initial begin
    repeat (30000) @(posedge ref_clk);
    mismatches++;
    end_sim();
  end

  // main sequence
  initial begin
    mismatches = 0;
    comparisons = 0;
    nrst = 1'b0;
    conversion_start_n = 1'b1;
    sel_sw = 1'b0;
    sel_hw = 4'h0;
    sel_word = 4'h0;
    seq_n = 10'h000;
    repeat (8) tick();
    chk("rst_busy", 0, busy);
    chk("rst_eoc_n", 1, eoc_n);
    chk("rst_db_oe", 0, db_oe);
    #4;
    nrst = 1'b1;
    t_all_sw();
    t_empty_read();
    t_subsets();
    t_read_during();
    t_empty_set();
    t_fifo_full();
    end_sim();
  end
endmodule : tb
